// ===== pes_pkg.sv
// pes_pkg: constants, types and register map of the pattern exposure sequencer
package pes_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned US_PS         = 1000000;
	localparam int unsigned US_PER_S      = 1000000;
	localparam int unsigned US_CYC        = US_PS / CLK_PERIOD_PS;
	localparam int unsigned FT_MIN_US     = 20;
	localparam int unsigned FT_CYC        = (FT_MIN_US * US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned EXT8_MAX_HZ   = 120;
	localparam int unsigned EXT8_MAX_PAT  = 3;
	localparam int unsigned EXT8_PAT_HZ   = EXT8_MAX_HZ * EXT8_MAX_PAT;
	localparam int unsigned EXT1_MAX_MHZ  = 104200;
	localparam int unsigned EXT1_MAX_PAT  = 24;
	localparam int unsigned EXT1_PAT_HZ   = 2500;
	localparam int unsigned MEM_DEPTH     = 16;
	localparam int unsigned IVL_W         = 20;
	localparam int unsigned PAT_W         = 24;
	localparam int unsigned CNT_W         = 5;
	localparam int unsigned MODE_W        = 2;
	localparam int unsigned ILL_W         = 3;
	localparam int unsigned ADDR_W        = 8;
	localparam int unsigned DATA_W        = 32;
	localparam logic [IVL_W-1:0] IVL_ZERO = 20'h0;
	localparam logic [IVL_W-1:0] IVL_ONE  = 20'h1;
	localparam logic [IVL_W-1:0] IVL_MAX  = 20'hfffff;
	localparam logic [IVL_W-1:0] EXT8_MIN_FRM_US = 20'(US_PER_S / EXT8_MAX_HZ);
	localparam logic [IVL_W-1:0] EXT1_MIN_FRM_US = 20'((US_PER_S / 100) * 100000 / EXT1_MAX_MHZ);
	localparam logic [IVL_W+1:0] EXT8_MIN_PAT_US = 22'(US_PER_S / EXT8_PAT_HZ);
	localparam logic [IVL_W+1:0] EXT1_MIN_PAT_US = 22'(US_PER_S / EXT1_PAT_HZ);
	localparam logic [7:0] PSC_LAST = 8'(US_CYC - 1);
	localparam logic [11:0] FT_LOAD = 12'(FT_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h1;
	localparam logic [CNT_W-1:0] CNT_EXT8 = 5'(EXT8_MAX_PAT);
	localparam logic [CNT_W-1:0] CNT_EXT1 = 5'(EXT1_MAX_PAT);
	localparam logic [CNT_W-1:0] CNT_MEM = 5'(MEM_DEPTH);
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_PRE    = 8'h04;
	localparam logic [ADDR_W-1:0] REG_LIT    = 8'h08;
	localparam logic [ADDR_W-1:0] REG_POST   = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_FTD    = 8'h10;
	localparam logic [ADDR_W-1:0] REG_PTD    = 8'h14;
	localparam logic [ADDR_W-1:0] REG_FRAME  = 8'h18;
	localparam logic [ADDR_W-1:0] REG_ILLUM8 = 8'h1c;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_RUN_BIT  = 2;
	localparam int unsigned CTRL_GO_BIT   = 3;
	localparam int unsigned CTRL_CNT_LSB  = 4;
	localparam int unsigned CTRL_ILL_LSB  = 9;
	localparam int unsigned CTRL_ROW_BIT  = 12;
	localparam int unsigned STS_OVR_BIT   = 9;
	localparam int unsigned STS_RERR_BIT  = 10;
	typedef enum logic [1:0] {
		MODE_EXT8 = 2'b00, MODE_EXT1 = 2'b01, MODE_FREE = 2'b10, MODE_TRIG = 2'b11
	} pes_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_LOAD = 3'b001, ST_PRE = 3'b010, ST_LIT = 3'b011,
		ST_POST = 3'b100, ST_FILL = 3'b101, ST_WTRIG = 3'b110
	} pes_state_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              re;
	} pes_bus_req_t;
endpackage

// ===== pes_sequencer.sv
// pes_sequencer: pattern exposure sequencer with register port and trigger outputs
`timescale 1ns/1ps
module pes_sequencer (
	input  wire logic                 clk_sys,                      // 200 MHz system clock
	input  wire logic                 arst_n,                       // async reset, active low
	input  wire pes_pkg::pes_bus_req_t bus,                         // register port request
	output logic [pes_pkg::DATA_W-1:0] rdata,                       // read data, cycle after read
	input  wire logic                 vsync_in,                     // input frame sync pin
	input  wire logic [pes_pkg::PAT_W-1:0] pixel_in,                // parallel pixel word pins
	input  wire logic                 pattern_advance_trigger_in,   // external trigger pin
	output logic                      flash_rd_req,                 // memory load request
	output logic [3:0]                flash_rd_addr,                // memory load entry
	input  wire logic [pes_pkg::PAT_W-1:0] flash_rd_data,           // memory load data
	input  wire logic                 flash_rd_valid,               // memory load data valid
	output logic                      frame_set_trigger_out,        // frame or set trigger
	output logic                      pattern_exposure_trigger_out, // per pattern trigger
	output logic                      pattern_ready,                // ready for trigger input
	output logic [pes_pkg::ILL_W-1:0] illum_en,                     // illuminator enables
	output logic [pes_pkg::PAT_W-1:0] show_data,                    // pattern shown on array
	output logic                      row_replicate                 // internal line is a row
);
	import pes_pkg::*;

	pes_mode_t               mode;
	pes_state_t              state, next_state;
	logic                    run, go, ovr, rerr, seen;
	logic [CNT_W-1:0]        cnt_cfg, npat, pat_idx;
	logic [ILL_W-1:0]        ill1, cur_ill;
	logic [3*ILL_W-1:0]      ill8;
	logic [IVL_W-1:0]        pre_ivl, lit_ivl, post_ivl, ftd, ptd, frm_per;
	logic [IVL_W-1:0]        st_us, pat_us, frm_us;
	logic [IVL_W+1:0]        sum3;
	logic [7:0]              psc;
	logic [11:0]             ft_cnt;
	logic                    ft_pend, ft_fire;
	logic [1:0]              vs_sy, tr_sy;
	logic                    vs_d, tr_d;
	logic [PAT_W-1:0]        px_s1, px_s2, frame_word, cur_data;
	logic [PAT_W-1:0]        mem [MEM_DEPTH];
	logic                    ext_mode, tick, vs_rise, tr_rise, trig_take, free_hit;
	logic                    ld_done, frm_start, last, running, rate_bad;
	logic                    pre_done, lit_done, post_done;

	function automatic logic ivl_done(input logic [IVL_W-1:0] len, input logic [IVL_W-1:0] cnt,
		input logic tk);
		return (len == IVL_ZERO) || (tk && cnt == len - IVL_ONE);
	endfunction

	// register writes
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mode <= MODE_EXT8;
			run <= 1'b0;
			cnt_cfg <= CNT_ONE;
			ill1 <= 3'h0;
			row_replicate <= 1'b0;
			ill8 <= 9'h0;
			pre_ivl <= IVL_ZERO;
			lit_ivl <= IVL_ZERO;
			post_ivl <= IVL_ZERO;
			ftd <= IVL_ZERO;
			ptd <= IVL_ZERO;
			frm_per <= IVL_ZERO;
		end else if (bus.we) begin
			unique case (bus.addr)
				REG_CTRL: begin
					mode <= pes_mode_t'(bus.wdata[CTRL_MODE_LSB +: MODE_W]);
					run <= bus.wdata[CTRL_RUN_BIT];
					cnt_cfg <= bus.wdata[CTRL_CNT_LSB +: CNT_W];
					ill1 <= bus.wdata[CTRL_ILL_LSB +: ILL_W];
					row_replicate <= bus.wdata[CTRL_ROW_BIT];
				end
				REG_PRE:    pre_ivl <= bus.wdata[IVL_W-1:0];
				REG_LIT:    lit_ivl <= bus.wdata[IVL_W-1:0];
				REG_POST:   post_ivl <= bus.wdata[IVL_W-1:0];
				REG_FTD:    ftd <= bus.wdata[IVL_W-1:0];
				REG_PTD:    ptd <= bus.wdata[IVL_W-1:0];
				REG_FRAME:  frm_per <= bus.wdata[IVL_W-1:0];
				REG_ILLUM8: ill8 <= bus.wdata[3*ILL_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			go <= 1'b0;
		else
			go <= bus.we && bus.addr == REG_CTRL && bus.wdata[CTRL_GO_BIT];
	end

	// register reads; unmapped addresses read zero
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 32'h0;
		end else if (bus.re) begin
			unique case (bus.addr)
				REG_CTRL:   rdata <= {19'h0, row_replicate, ill1, cnt_cfg, 1'b0, run, mode};
				REG_PRE:    rdata <= {12'h0, pre_ivl};
				REG_LIT:    rdata <= {12'h0, lit_ivl};
				REG_POST:   rdata <= {12'h0, post_ivl};
				REG_FTD:    rdata <= {12'h0, ftd};
				REG_PTD:    rdata <= {12'h0, ptd};
				REG_FRAME:  rdata <= {12'h0, frm_per};
				REG_ILLUM8: rdata <= {23'h0, ill8};
				REG_STATUS: rdata <= {21'h0, rerr, ovr, pat_idx, 1'b0, state};
				default:    rdata <= 32'h0;
			endcase
		end else begin
			rdata <= 32'h0;
		end
	end

	// pin synchronisers; the pixel word is assumed stable around the sync edge
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			vs_sy <= 2'h0;
			tr_sy <= 2'h0;
			vs_d <= 1'b0;
			tr_d <= 1'b0;
			px_s1 <= 24'h0;
			px_s2 <= 24'h0;
		end else begin
			vs_sy <= {vs_sy[0], vsync_in};
			tr_sy <= {tr_sy[0], pattern_advance_trigger_in};
			vs_d <= vs_sy[1];
			tr_d <= tr_sy[1];
			px_s1 <= pixel_in;
			px_s2 <= px_s1;
		end
	end

	assign vs_rise = vs_sy[1] && !vs_d;
	assign tr_rise = tr_sy[1] && !tr_d;
	assign ext_mode = (mode == MODE_EXT8) || (mode == MODE_EXT1);
	assign tick = (psc == PSC_LAST);
	assign running = (state == ST_PRE) || (state == ST_LIT) || (state == ST_POST);

	always_comb begin
		npat = (cnt_cfg == 5'h0) ? CNT_ONE : cnt_cfg;
		unique case (mode)
			MODE_EXT8: if (cnt_cfg > CNT_EXT8) npat = CNT_EXT8;
			MODE_EXT1: if (cnt_cfg > CNT_EXT1) npat = CNT_EXT1;
			MODE_FREE, MODE_TRIG: if (cnt_cfg > CNT_MEM) npat = CNT_MEM;
		endcase
	end

	assign last = (pat_idx == 5'(npat - CNT_ONE));
	// only the ready window admits a trigger; external modes never open it
	assign pattern_ready = (mode == MODE_TRIG) && (state == ST_WTRIG);
	assign trig_take = pattern_ready && tr_rise;
	assign ld_done = (state == ST_LOAD) && flash_rd_valid && (flash_rd_addr == npat[3:0] - 4'h1);
	assign free_hit = (mode == MODE_FREE) && (running || state == ST_FILL) && tick
		&& frm_per != IVL_ZERO && frm_us == frm_per - IVL_ONE;
	assign frm_start = (ext_mode && run && vs_rise && state != ST_IDLE)
		|| free_hit || (ld_done && mode == MODE_FREE) || trig_take;
	assign pre_done = ivl_done(pre_ivl, st_us, tick);
	assign lit_done = ivl_done(lit_ivl, st_us, tick);
	assign post_done = ivl_done(post_ivl, st_us, tick);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE:  if (run && ext_mode) next_state = ST_FILL;
				else if (run && go) next_state = ST_LOAD;
			ST_LOAD:  if (ld_done && mode == MODE_TRIG) next_state = ST_WTRIG;
			ST_PRE:   if (pre_done) next_state = ST_LIT;
			ST_LIT:   if (lit_done) next_state = ST_POST;
			ST_POST:  if (post_done) begin
				if (mode == MODE_TRIG)
					next_state = ST_WTRIG;
				else if (last)
					next_state = ST_FILL;
				else
					next_state = ST_PRE;
			end
			ST_FILL:  next_state = ST_FILL;
			ST_WTRIG: next_state = ST_WTRIG;
			default:  next_state = ST_IDLE;
		endcase
		// a new frame restarts the sequence even mid-pattern
		if (frm_start)
			next_state = ST_PRE;
		if (!run)
			next_state = ST_IDLE;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// microsecond timebase, realigned on each frame so intervals start on a tick
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			psc <= 8'h0;
		else if (frm_start || tick)
			psc <= 8'h0;
		else
			psc <= psc + 8'h1;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_us <= IVL_ZERO;
			pat_us <= IVL_ZERO;
			frm_us <= IVL_MAX;
		end else begin
			if (next_state != state || frm_start)
				st_us <= IVL_ZERO;
			else if (tick && st_us != IVL_MAX)
				st_us <= st_us + IVL_ONE;
			if (frm_start || (state == ST_POST && next_state == ST_PRE))
				pat_us <= IVL_ZERO;
			else if (tick && pat_us != IVL_MAX)
				pat_us <= pat_us + IVL_ONE;
			if (frm_start)
				frm_us <= IVL_ZERO;
			else if (tick && frm_us != IVL_MAX)
				frm_us <= frm_us + IVL_ONE;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			pat_idx <= 5'h0;
		else if (state == ST_IDLE || state == ST_LOAD)
			pat_idx <= 5'h0;
		else if (frm_start && mode != MODE_TRIG)
			pat_idx <= 5'h0;
		else if (state == ST_POST && post_done)
			pat_idx <= last ? 5'h0 : 5'(pat_idx + CNT_ONE);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			frame_word <= 24'h0;
		else if (frm_start && ext_mode)
			frame_word <= px_s2;
	end

	// internal line memory fill; data array has no reset on purpose
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			flash_rd_addr <= 4'h0;
		else if (state != ST_LOAD)
			flash_rd_addr <= 4'h0;
		else if (flash_rd_valid && !ld_done)
			flash_rd_addr <= flash_rd_addr + 4'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (state == ST_LOAD && flash_rd_valid)
			mem[flash_rd_addr] <= flash_rd_data;
	end
	assign flash_rd_req = (state == ST_LOAD);

	always_comb begin
		cur_ill = ill1;
		cur_data = mem[pat_idx[3:0]];
		unique case (mode)
			MODE_EXT8: begin
				cur_ill = ill8[pat_idx[1:0] * ILL_W +: ILL_W];
				cur_data = {16'h0, frame_word[pat_idx[1:0] * 8 +: 8]};
			end
			MODE_EXT1: cur_data = {PAT_W{frame_word[pat_idx]}};
			MODE_FREE, MODE_TRIG: ;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			illum_en <= 3'h0;
			show_data <= 24'h0;
		end else if (state == ST_LIT) begin
			illum_en <= cur_ill;
			show_data <= cur_data;
		end else begin
			illum_en <= 3'h0;
			show_data <= 24'h0;
		end
	end

	// frame trigger: delay counted from whichever event opened the frame or set
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			ft_pend <= 1'b0;
		else if (state == ST_IDLE || ft_fire)
			ft_pend <= 1'b0;
		else if (frm_start && (mode != MODE_TRIG || pat_idx == 5'h0))
			ft_pend <= 1'b1;
	end
	assign ft_fire = ft_pend && !frm_start && frm_us >= ftd;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ft_cnt <= 12'h0;
			frame_set_trigger_out <= 1'b0;
		end else if (ft_fire) begin
			ft_cnt <= FT_LOAD;
			frame_set_trigger_out <= 1'b1;
		end else if (ft_cnt != 12'h0) begin
			ft_cnt <= ft_cnt - 12'h1;
			if (ft_cnt == 12'h1)
				frame_set_trigger_out <= 1'b0;
		end
	end

	// pattern trigger window is the exposure length, shifted by its own delay ptd
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			pattern_exposure_trigger_out <= 1'b0;
		else
			pattern_exposure_trigger_out <= running && pat_us >= ptd
				&& {1'b0, pat_us} < {1'b0, ptd} + {1'b0, lit_ivl};
	end

	// status: overrun and rate violations, sticky; a new event beats the clear
	assign sum3 = {2'b0, pre_ivl} + {2'b0, lit_ivl} + {2'b0, post_ivl};
	assign rate_bad = ext_mode && frm_start && ((seen && frm_us <
		(mode == MODE_EXT8 ? EXT8_MIN_FRM_US : EXT1_MIN_FRM_US))
		|| sum3 < (mode == MODE_EXT8 ? EXT8_MIN_PAT_US : EXT1_MIN_PAT_US));
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ovr <= 1'b0;
			rerr <= 1'b0;
			seen <= 1'b0;
		end else begin
			seen <= (state != ST_IDLE) && (seen || frm_start);
			if (frm_start && running && mode != MODE_TRIG)
				ovr <= 1'b1;
			else if (bus.we && bus.addr == REG_STATUS && bus.wdata[STS_OVR_BIT])
				ovr <= 1'b0;
			if (rate_bad)
				rerr <= 1'b1;
			else if (bus.we && bus.addr == REG_STATUS && bus.wdata[STS_RERR_BIT])
				rerr <= 1'b0;
		end
	end

	// checks
	int unsigned ft_hi;
	int unsigned lit_cyc;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ft_hi <= 0;
			lit_cyc <= 0;
		end else begin
			ft_hi <= frame_set_trigger_out ? ft_hi + 1 : 0;
			lit_cyc <= (state == ST_LIT) ? lit_cyc + 1 : 0;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	property p_dark_off;
		state != ST_LIT |=> illum_en == 3'h0 && show_data == 24'h0;
	endproperty
	a_dark_off: assert property (p_dark_off) else $error("light on outside exposure");
	property p_one_ill;
		state == ST_LIT && mode != MODE_EXT8 |=> illum_en == $past(ill1);
	endproperty
	a_one_ill: assert property (p_one_ill) else $error("frame illuminator wrong");
	property p_byte_lane;
		state == ST_LIT && mode == MODE_EXT8 && pat_idx == 5'h1 |=> show_data[7:0] == $past(frame_word[15:8])
			&& illum_en == $past(ill8[5:3]);
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("second byte pattern wrong");
	property p_ft_width;
		$fell(frame_set_trigger_out) |-> ft_hi >= FT_CYC;
	endproperty
	a_ft_width: assert property (p_ft_width) else $error("frame trigger too short");
	property p_ext_ignore;
		ext_mode && run && state == ST_FILL && !vs_rise |=> state == ST_FILL || state == ST_IDLE;
	endproperty
	a_ext_ignore: assert property (p_ext_ignore) else $error("frame left without sync");
	property p_take;
		trig_take |=> state == ST_PRE && !pattern_ready;
	endproperty
	a_take: assert property (p_take) else $error("trigger did not start pattern");
	property p_edge;
		tr_rise |=> !tr_rise;
	endproperty
	a_edge: assert property (p_edge) else $error("trigger edge repeated");
	property p_lit_len;
		state == ST_LIT && next_state == ST_POST && pre_ivl != IVL_ZERO && lit_ivl != IVL_ZERO
			|-> lit_cyc == lit_ivl * US_CYC - 1;
	endproperty
	a_lit_len: assert property (p_lit_len) else $error("exposure length wrong");
	property p_fill;
		state == ST_POST && next_state == ST_FILL |-> last ##1 state == ST_FILL && illum_en == 3'h0;
	endproperty
	a_fill: assert property (p_fill) else $error("dark fill before last pattern");
	property p_ptrig;
		pattern_exposure_trigger_out |-> $past(pat_us) >= $past(ptd);
	endproperty
	a_ptrig: assert property (p_ptrig) else $error("pattern trigger before delay");

	c_frame_trig: cover property (ft_fire);
	c_trig_take:  cover property (trig_take ##[1:1000] state == ST_WTRIG);
	c_load:       cover property (ld_done && mode == MODE_FREE);
	c_three:      cover property (mode == MODE_EXT8 && state == ST_LIT && pat_idx == 5'h2);
endmodule // pes_sequencer

// ===== pes_far_model.sv
// pes_far_model: pattern memory source and trigger source facing the sequencer
`timescale 1ns/1ps
module pes_far_model (
	input  wire logic        clk_sys,        // system clock
	input  wire logic        arst_n,         // async reset, active low
	input  wire logic        flash_rd_req,   // load request
	input  wire logic [3:0]  flash_rd_addr,  // entry asked for
	output logic [23:0]      flash_rd_data,  // entry data
	output logic             flash_rd_valid, // data valid pulse
	input  wire logic        pattern_ready,  // sequencer ready
	input  wire logic        trig_req,       // bench asks for one trigger
	input  wire logic        rude,           // fire even while not ready
	output logic             trig_out        // trigger pin
);
	logic       pend;
	logic [2:0] hold;
	// one entry every other cycle, so the address has moved on before the next pulse
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) flash_rd_valid <= 1'b0;
		else flash_rd_valid <= flash_rd_req && !flash_rd_valid;
	end
	// released data lines show the inverse, never a stale entry
	assign flash_rd_data = flash_rd_valid ? {4'h0, flash_rd_addr, 16'hc35a} : ~{4'h0, flash_rd_addr, 16'hc35a};
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pend <= 1'b0;
			hold <= 3'h0;
		end else if (pend && (pattern_ready || rude)) begin
			pend <= 1'b0;
			hold <= 3'h4;
		end else begin
			pend <= pend || trig_req;
			hold <= (hold != 3'h0) ? hold - 3'h1 : 3'h0;
		end
	end
	assign trig_out = (hold != 3'h0);
endmodule // pes_far_model

// ===== pattern_exposure_sequencer_tb.sv
// pattern_exposure_sequencer_tb: self-checking bench of the sequencer
`timescale 1ns/1ps
module pattern_exposure_sequencer_tb;
	import pes_pkg::*;
	logic         clk_sys = 1'b0;
	logic         arst_n = 1'b0;
	logic         vsync_in = 1'b0;
	logic         trig_req = 1'b0;
	logic         rude = 1'b0;
	logic [23:0]  pixel_in = 24'h0;
	pes_bus_req_t bus = '0;
	logic [31:0]  rdata, v;
	logic [23:0]  show_data, flash_rd_data;
	logic [3:0]   flash_rd_addr;
	logic [2:0]   illum_en;
	logic         fst, pet, pattern_ready, row_replicate, flash_rd_req, flash_rd_valid, trig;
	int           num_errors = 0;
	int           total_checks = 0;
	int           cyc = 0;

	always #2.5 clk_sys = ~clk_sys;

	pes_sequencer u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus), .rdata(rdata), .vsync_in(vsync_in),
		.pixel_in(pixel_in), .pattern_advance_trigger_in(trig), .flash_rd_req(flash_rd_req),
		.flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .flash_rd_valid(flash_rd_valid),
		.frame_set_trigger_out(fst), .pattern_exposure_trigger_out(pet), .pattern_ready(pattern_ready),
		.illum_en(illum_en), .show_data(show_data), .row_replicate(row_replicate));
	pes_far_model u_far (.clk_sys(clk_sys), .arst_n(arst_n), .flash_rd_req(flash_rd_req),
		.flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .flash_rd_valid(flash_rd_valid),
		.pattern_ready(pattern_ready), .trig_req(trig_req), .rude(rude), .trig_out(trig));

	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys) bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys) bus <= '0;
		#1 d = rdata;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic pulse_trig;
		@(posedge clk_sys) trig_req <= 1'b1;
		@(posedge clk_sys) trig_req <= 1'b0;
	endtask
	// setup shared by all modes: 1 us dark, lit and dark, trigger at lit start
	task automatic cfg(input logic [31:0] ftd, input logic [31:0] ctrl);
		wr(REG_CTRL, 32'h0);
		wr(REG_PRE, 32'h1);
		wr(REG_LIT, 32'h1);
		wr(REG_POST, 32'h1);
		wr(REG_PTD, 32'h1);
		wr(REG_FTD, ftd);
		wr(REG_FRAME, 32'd30);
		wr(REG_CTRL, ctrl);
	endtask
	task automatic run_lit(input logic [2:0] ill, input logic [23:0] pat);
		int n;
		n = 0;
		while (illum_en === 3'h0 && n < 3000) begin tick(1); n++; end
		tick(2);
		chk(illum_en, ill);
		chk(show_data, pat);
		chk(pet, 1'b1);
		n = 2;
		while (illum_en !== 3'h0 && n < 3000) begin tick(1); n++; end
		chk(n, 200);
	endtask
	task automatic ft_check(input int lo, input int hi);
		int n, m;
		n = 0;
		m = 0;
		while (fst !== 1'b1 && n < 9000) begin tick(1); n++; end
		chk(n >= lo && n <= hi, 1'b1);
		while (fst === 1'b1 && m < 9000) begin tick(1); m++; end
		chk(m, FT_CYC);
	endtask

	task automatic t_regs;
		rd(REG_STATUS, v);
		chk(v, 32'h0);
		rd(8'h44, v);
		chk(v, 32'h0);
		wr(REG_PTD, 32'h5);
		rd(REG_PTD, v);
		chk(v, 32'h5);
	endtask
	task automatic t_ext8;
		wr(REG_ILLUM8, 32'h21);
		pixel_in <= 24'h33a55a;
		cfg(32'h2, 32'h24);
		fork
			ft_check(398, 420);
			begin
				@(posedge clk_sys) vsync_in <= 1'b1;
				tick(100);
				chk(illum_en, 3'h0);
				chk(show_data, 24'h0);
				run_lit(3'h1, 24'h5a);
				run_lit(3'h4, 24'ha5);
				tick(300);
				rd(REG_STATUS, v);
				chk(v[2:0], 3'h5);
				chk(v[10:9], 2'h2);
				chk(illum_en, 3'h0);
				wr(REG_STATUS, 32'h400);
				rd(REG_STATUS, v);
				chk(v[10:9], 2'h0);
			end
		join
		@(posedge clk_sys) vsync_in <= 1'b0;
	endtask
	task automatic t_ext1;
		pixel_in <= 24'h000001;
		cfg(32'h0, 32'h425);
		rude <= 1'b1;
		pulse_trig;
		tick(300);
		chk(illum_en, 3'h0);
		chk(pet, 1'b0);
		@(posedge clk_sys) rude <= 1'b0;
		// the frame trigger must have ended before the next scenario looks for its rise
		fork
			ft_check(3, 12);
			begin
				@(posedge clk_sys) vsync_in <= 1'b1;
				run_lit(3'h2, 24'hffffff);
				run_lit(3'h2, 24'h0);
			end
		join
		@(posedge clk_sys) vsync_in <= 1'b0;
	endtask
	task automatic t_trig;
		int n;
		cfg(32'h1, 32'h142f);
		n = 0;
		while (pattern_ready !== 1'b1 && n < 300) begin tick(1); n++; end
		chk(pattern_ready, 1'b1);
		chk(row_replicate, 1'b1);
		fork
			ft_check(198, 225);
			begin
				pulse_trig;
				run_lit(3'h2, 24'h00c35a);
			end
		join
		n = 0;
		while (pattern_ready !== 1'b1 && n < 900) begin tick(1); n++; end
		chk(pattern_ready, 1'b1);
		pulse_trig;
		run_lit(3'h2, 24'h01c35a);
	endtask
	task automatic t_free;
		cfg(32'h0, 32'h21e);
		fork
			ft_check(0, 20);
			run_lit(3'h1, 24'h00c35a);
		join
		ft_check(1995, 2010);
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			num_errors++;
			stop_test;
		end
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_regs;
		t_ext8;
		t_ext1;
		t_trig;
		t_free;
		stop_test;
	end
endmodule // pattern_exposure_sequencer_tb
